// ---- verilog/rx_packet_handler.sv ----
// receive packet handler: sync search, length, address, check word,
// trailer bytes, serial bypass and channel frequency word
// assumes demodulated bits arrive synchronous to clk_i, msb first
//
// Behaviour
// - sync high byte from high register
// - sync low byte from low register
// - fixed mode: limit is exact payload length
// - auto-flush buffer on failed check word
// - append signal strength and check-pass bytes
// - filter select code picks broadcast set
// - compare address byte with own address
// - data format picks buffer or serial path
// - serial data leaves on general output zero
// - check word computed only when enabled
// - length mode: fixed, first byte, infinite
// - frequency word: base plus channel times spacing
module rx_packet_handler
  import rx_pkt_pkg::*;
#(
  parameter int OUT_PINS = 3
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // register port
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  output logic [7:0]               reg_rdata_o,
  // demodulated bits
  input  wire logic                bit_i,
  input  wire logic                bit_valid_i,
  output logic                     bit_ready_o,
  input  wire logic [7:0]          rssi_i,
  // received bytes
  output logic [7:0]               fifo_data_o,
  output logic                     fifo_valid_o,
  input  wire logic                fifo_ready_i,
  output logic                     flush_o,
  // serial path
  output logic                     general_output_zero_o,
  output logic [OUT_PINS-1:0]      general_output_pins_o,
  // synthesizer word
  input  wire logic [23:0]         base_freq_i,
  input  wire logic [15:0]         spacing_i,
  output logic [23:0]              freq_word_o
);
  import rx_pkt_pkg::*;

  // register state
  logic [7:0] sync_hi_r, sync_hi_nxt;
  logic [7:0] sync_lo_r, sync_lo_nxt;
  logic [7:0] limit_r, limit_nxt;
  logic [7:0] ctrl_a_r, ctrl_a_nxt;
  logic [7:0] ctrl_b_r, ctrl_b_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] channel_index_r, channel_index_nxt;

  // decoded fields
  logic       flush_on_bad_check;
  logic       add_trailer_bytes;
  filter_t    filter_select;
  rx_format_t rx_data_format;
  logic       crc_en;
  len_mode_t  len_mode;

  // framing state
  fsm_state_t st_r, st_nxt;
  logic [15:0] sync_sh_r, sync_sh_nxt;
  logic [7:0]  byte_sh_r, byte_sh_nxt;
  logic [2:0]  bitcnt_r, bitcnt_nxt;
  logic [7:0]  rem_r, rem_nxt;
  logic        addr_pend_r, addr_pend_nxt;
  logic        crc_ok_r, crc_ok_nxt;
  logic        flush_nxt;
  logic        ser_data_nxt, ser_clk_nxt, ser_clk_r;
  logic [23:0] freq_nxt;

  // datapath helpers
  logic        take_bit;
  logic        byte_done;
  logic [7:0]  new_byte;
  logic        sync_hit;
  logic        crc_shift;
  logic        crc_zero;
  logic        push;
  logic [7:0]  push_data;

  byte_stream_if #(.W(8)) buf_in ();
  byte_stream_if #(.W(8)) buf_out ();

  // register writes
  always_comb begin
    sync_hi_nxt       = sync_hi_r;
    sync_lo_nxt       = sync_lo_r;
    limit_nxt         = limit_r;
    ctrl_a_nxt        = ctrl_a_r;
    ctrl_b_nxt        = ctrl_b_r;
    addr_nxt          = addr_r;
    channel_index_nxt = channel_index_r;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_SYNC_HI: sync_hi_nxt = reg_wdata_i;
        OFS_SYNC_LO: sync_lo_nxt = reg_wdata_i;
        OFS_LIMIT:   limit_nxt = reg_wdata_i;
        OFS_CTRL_A:  ctrl_a_nxt = reg_wdata_i & CTRL_A_WMASK;
        OFS_CTRL_B:  ctrl_b_nxt = reg_wdata_i & CTRL_B_WMASK;
        OFS_ADDR:    addr_nxt = reg_wdata_i;
        OFS_CHANNEL_INDEX:    channel_index_nxt = reg_wdata_i;
        default: ; // writes elsewhere are ignored
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_hi_r       <= RST_SYNC_HI;
      sync_lo_r       <= RST_SYNC_LO;
      limit_r         <= RST_LIMIT;
      ctrl_a_r        <= RST_CTRL_A;
      ctrl_b_r        <= RST_CTRL_B;
      addr_r          <= RST_ADDR;
      channel_index_r <= RST_CHANNEL_INDEX;
    end else if (ce_i) begin
      sync_hi_r       <= sync_hi_nxt;
      sync_lo_r       <= sync_lo_nxt;
      limit_r         <= limit_nxt;
      ctrl_a_r        <= ctrl_a_nxt;
      ctrl_b_r        <= ctrl_b_nxt;
      addr_r          <= addr_nxt;
      channel_index_r <= channel_index_nxt;
    end
  end

  // register reads, combinational; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr_i)
      OFS_SYNC_HI: reg_rdata_o = sync_hi_r;
      OFS_SYNC_LO: reg_rdata_o = sync_lo_r;
      OFS_LIMIT:   reg_rdata_o = limit_r;
      OFS_CTRL_A:  reg_rdata_o = ctrl_a_r;
      OFS_CTRL_B:  reg_rdata_o = ctrl_b_r;
      OFS_ADDR:    reg_rdata_o = addr_r;
      OFS_CHANNEL_INDEX:    reg_rdata_o = channel_index_r;
      OFS_STATUS:  reg_rdata_o = {crc_ok_r, ~st_r[0], 5'h00, buf_out.valid};
      default:     reg_rdata_o = 8'h00;
    endcase
  end

  // field decode
  assign flush_on_bad_check = ctrl_a_r[CA_FLUSH_BIT];
  assign add_trailer_bytes  = ctrl_a_r[CA_APPEND_BIT];
  assign filter_select      = filter_t'(ctrl_a_r[CA_FILT_LSB +: 2]);
  assign rx_data_format     = rx_format_t'(ctrl_b_r[CB_FMT_LSB +: 2]);
  assign crc_en             = ctrl_b_r[CB_CRC_BIT];
  assign len_mode           = len_mode_t'(ctrl_b_r[CB_LEN_LSB +: 2]);

  // address acceptance for the current filter code
  function automatic logic filter_hit(input filter_t f, input logic [7:0] a,
                                      input logic [7:0] own);
    unique case (f)
      FILT_OFF:  filter_hit = 1'b1;
      FILT_OWN:  filter_hit = (a == own);
      FILT_BC0:  filter_hit = (a == own) || (a == BCAST_ZERO);
      FILT_BC01: filter_hit = (a == own) || (a == BCAST_ZERO) || (a == BCAST_ONES);
    endcase
  endfunction : filter_hit

  // in buffer mode, bit intake stalls during the verdict, while trailer bytes are inserted or while the buffer is full
  assign bit_ready_o = ce_i && ((rx_data_format != FMT_FIFO) ||
                       (buf_in.ready && !(st_r inside {ST_VERDICT, ST_TRAIL_A, ST_TRAIL_B})));
  assign take_bit  = bit_valid_i && bit_ready_o;
  assign new_byte  = {byte_sh_r[6:0], bit_i};
  assign byte_done = take_bit && (bitcnt_r == 3'd7);
  assign sync_hit  = take_bit && (st_r == ST_HUNT) && (rx_data_format == FMT_FIFO) && // hunt only
                     ({sync_sh_r[14:0], bit_i} == {sync_hi_r, sync_lo_r});
  assign crc_shift = take_bit && crc_en &&
                     (st_r inside {ST_LENGTH, ST_PAYLOAD, ST_CHECK});

  // framing next state
  always_comb begin
    st_nxt        = st_r;
    rem_nxt       = rem_r;
    addr_pend_nxt = addr_pend_r;
    crc_ok_nxt    = crc_ok_r;
    flush_nxt     = 1'b0;
    push          = 1'b0;
    push_data     = new_byte;
    sync_sh_nxt   = take_bit ? {sync_sh_r[14:0], bit_i} : sync_sh_r;
    byte_sh_nxt   = take_bit ? new_byte : byte_sh_r;
    bitcnt_nxt    = take_bit ? bitcnt_r + 3'd1 : bitcnt_r;
    unique case (st_r)
      ST_HUNT: begin
        if (sync_hit && st_r == ST_HUNT) begin
          bitcnt_nxt    = 3'd0;
          addr_pend_nxt = (filter_select != FILT_OFF);
          rem_nxt       = limit_r;
          st_nxt        = (len_mode == LEN_VAR) ? ST_LENGTH : ST_PAYLOAD;
        end
      end
      ST_LENGTH: begin
        if (byte_done) begin
          if (new_byte > limit_r) begin
            flush_nxt = 1'b1;
            st_nxt    = ST_HUNT;
          end else begin
            push    = 1'b1;
            rem_nxt = new_byte;
            if (new_byte == 8'h00) begin
              st_nxt = crc_en ? ST_CHECK : (add_trailer_bytes ? ST_TRAIL_A : ST_HUNT);
              rem_nxt = CHECK_BYTES;
            end else begin
              st_nxt = ST_PAYLOAD;
            end
          end
        end
      end
      ST_PAYLOAD: begin
        if (byte_done) begin
          if (addr_pend_r && !filter_hit(filter_select, new_byte, addr_r)) begin
            flush_nxt = 1'b1;
            st_nxt    = ST_HUNT;
          end else begin
            push          = 1'b1;
            addr_pend_nxt = 1'b0;
            if (len_mode != LEN_INF) begin
              rem_nxt = rem_r - 8'h01;
              if (rem_r == 8'h01) begin
                rem_nxt = CHECK_BYTES;
                st_nxt  = crc_en ? ST_CHECK : (add_trailer_bytes ? ST_TRAIL_A : ST_HUNT);
                crc_ok_nxt = 1'b1;
              end
            end
          end
        end
      end
      ST_CHECK: begin
        if (byte_done) begin
          rem_nxt = rem_r - 8'h01;
          if (rem_r == 8'h01) begin
            st_nxt = ST_VERDICT;
          end
        end
      end
      ST_VERDICT: begin
        crc_ok_nxt = crc_zero;
        if (!crc_zero && flush_on_bad_check) begin
          flush_nxt = 1'b1;
          st_nxt    = ST_HUNT;
        end else begin
          st_nxt = add_trailer_bytes ? ST_TRAIL_A : ST_HUNT;
        end
      end
      ST_TRAIL_A: begin
        push      = 1'b1;
        push_data = rssi_i;
        if (buf_in.ready) begin
          st_nxt = ST_TRAIL_B;
        end
      end
      ST_TRAIL_B: begin
        push      = 1'b1;
        push_data = {crc_ok_r, 7'h00};
        if (buf_in.ready) begin
          st_nxt = ST_HUNT;
        end
      end
    endcase
  end

  // serial bypass and frequency word
  always_comb begin
    ser_data_nxt = general_output_zero_o;
    ser_clk_nxt  = 1'b0;
    if (take_bit && rx_data_format != FMT_FIFO) begin
      ser_data_nxt = bit_i;
      ser_clk_nxt  = (rx_data_format == FMT_SYNC);
    end
    freq_nxt = base_freq_i + 24'(channel_index_r) * 24'(spacing_i);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r                  <= ST_HUNT;
      sync_sh_r             <= 16'h0000;
      byte_sh_r             <= 8'h00;
      bitcnt_r              <= 3'd0;
      rem_r                 <= 8'h00;
      addr_pend_r           <= 1'b0;
      crc_ok_r              <= 1'b0;
      flush_o               <= 1'b0;
      general_output_zero_o <= 1'b0;
      ser_clk_r             <= 1'b0;
      freq_word_o           <= 24'h000000;
    end else if (ce_i) begin
      st_r                  <= st_nxt;
      sync_sh_r             <= sync_sh_nxt;
      byte_sh_r             <= byte_sh_nxt;
      bitcnt_r              <= bitcnt_nxt;
      rem_r                 <= rem_nxt;
      addr_pend_r           <= addr_pend_nxt;
      crc_ok_r              <= crc_ok_nxt;
      flush_o               <= flush_nxt;
      general_output_zero_o <= ser_data_nxt;
      ser_clk_r             <= ser_clk_nxt;
      freq_word_o           <= freq_nxt;
    end
  end

  // pins: data, sync clock, packet in progress
  assign general_output_pins_o = OUT_PINS'({~st_r[0], ser_clk_r, general_output_zero_o});

  // byte path through the two-entry buffer
  assign buf_in.valid = push && ce_i;
  assign buf_in.data  = push_data;
  assign buf_out.ready = fifo_ready_i;
  assign fifo_valid_o  = buf_out.valid;
  assign fifo_data_o   = buf_out.data;

  two_entry_buffer u_buf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .flush_i (flush_o),
    .in_s    (buf_in),
    .out_s   (buf_out)
  );

  crc16_unit u_crc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .init_i  (sync_hit),
    .shift_i (crc_shift),
    .bit_i   (bit_i),
    .zero_o  (crc_zero)
  );

  a_sync_word_hit: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_HUNT && sync_hit |=> st_r != ST_HUNT && bitcnt_r == 3'd0)
    else $error("sync match did not start a packet");
  a_fixed_len_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && sync_hit && len_mode == LEN_FIXED |=> rem_r == $past(limit_r) && st_r == ST_PAYLOAD)
    else $error("fixed length not loaded from limit");
  a_var_len_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_LENGTH && byte_done && new_byte > limit_r
    |-> !buf_in.valid ##1 flush_o && st_r == ST_HUNT)
    else $error("oversize packet not dropped");
  a_var_len_take: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_LENGTH && byte_done && new_byte != 8'h00 && new_byte <= limit_r
    |=> rem_r == $past(new_byte) && st_r == ST_PAYLOAD)
    else $error("length byte not taken");
  a_bad_check_flush: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_VERDICT && !crc_zero && flush_on_bad_check |=> flush_o && !crc_ok_r)
    else $error("failed check word not flushed");
  a_trailer_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_TRAIL_A && buf_in.ready
    |-> buf_in.data == rssi_i ##1 st_r == ST_TRAIL_B && buf_in.data[7] == crc_ok_r)
    else $error("trailer bytes out of order");
  a_addr_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_PAYLOAD && addr_pend_r && byte_done &&
    filter_select == FILT_OWN && new_byte != addr_r |-> !buf_in.valid ##1 flush_o)
    else $error("foreign address accepted");
  a_serial_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rx_data_format != FMT_FIFO && take_bit
    |=> general_output_zero_o == $past(bit_i) && st_r == $past(st_r))
    else $error("serial path wrong");
  a_channel_word: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> freq_word_o == $past(base_freq_i + 24'(channel_index_r) * 24'(spacing_i)))
    else $error("frequency word wrong");
endmodule : rx_packet_handler

// ---- include/rx_pkt_pkg.sv ----
// constants for the receive packet handler
// assumes one 8-bit register port and a 40 MHz core clock
package rx_pkt_pkg;
  // register offsets
  localparam logic [7:0] OFS_SYNC_HI = 8'h04;
  localparam logic [7:0] OFS_SYNC_LO = 8'h05;
  localparam logic [7:0] OFS_LIMIT   = 8'h06;
  localparam logic [7:0] OFS_CTRL_A  = 8'h07;
  localparam logic [7:0] OFS_CTRL_B  = 8'h08;
  localparam logic [7:0] OFS_ADDR    = 8'h09;
  localparam logic [7:0] OFS_CHANNEL_INDEX    = 8'h0a;
  localparam logic [7:0] OFS_STATUS  = 8'h30;
  // reset values
  localparam logic [7:0] RST_SYNC_HI = 8'hd3;
  localparam logic [7:0] RST_SYNC_LO = 8'h91;
  localparam logic [7:0] RST_LIMIT   = 8'hff;
  localparam logic [7:0] RST_CTRL_A  = 8'h04;
  localparam logic [7:0] RST_CTRL_B  = 8'h45;
  localparam logic [7:0] RST_ADDR    = 8'h00;
  localparam logic [7:0] RST_CHANNEL_INDEX    = 8'h00;
  // writable bits; bits outside the mask read zero
  localparam logic [7:0] CTRL_A_WMASK = 8'hef;
  localparam logic [7:0] CTRL_B_WMASK = 8'h77;
  // field positions
  localparam int CA_FLUSH_BIT  = 3;
  localparam int CA_APPEND_BIT = 2;
  localparam int CA_FILT_LSB   = 0;
  localparam int CB_FMT_LSB    = 4;
  localparam int CB_CRC_BIT    = 2;
  localparam int CB_LEN_LSB    = 0;
  // broadcast addresses and check word
  localparam logic [7:0]  BCAST_ZERO = 8'h00;
  localparam logic [7:0]  BCAST_ONES = 8'hff;
  localparam logic [7:0]  CHECK_BYTES = 8'h02;
  localparam logic [15:0] CRC_POLY   = 16'h8005;
  localparam logic [15:0] CRC_INIT   = 16'hffff;

  typedef enum logic [1:0] {
    FMT_FIFO = 2'h0, FMT_SYNC = 2'h1, FMT_RSVD = 2'h2, FMT_ASYNC = 2'h3
  } rx_format_t;
  typedef enum logic [1:0] {
    LEN_FIXED = 2'h0, LEN_VAR = 2'h1, LEN_INF = 2'h2, LEN_RSVD = 2'h3
  } len_mode_t;
  typedef enum logic [1:0] {
    FILT_OFF = 2'h0, FILT_OWN = 2'h1, FILT_BC0 = 2'h2, FILT_BC01 = 2'h3
  } filter_t;
  typedef enum logic [6:0] {
    ST_HUNT    = 7'h01,
    ST_LENGTH  = 7'h02,
    ST_PAYLOAD = 7'h04,
    ST_CHECK   = 7'h08,
    ST_VERDICT = 7'h10,
    ST_TRAIL_A = 7'h20,
    ST_TRAIL_B = 7'h40
  } fsm_state_t;
endpackage : rx_pkt_pkg

// ---- include/byte_stream_if.sv ----
// valid/ready byte stream between handler and its buffer
// assumes both ends share one clock
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// ---- verilog/crc16_unit.sv ----
// bit-serial check-word engine, msb first
// assumes the caller seeds it at sync and shifts payload bits in
module crc16_unit
  import rx_pkt_pkg::*;
#(
  parameter logic [15:0] POLY = CRC_POLY,
  parameter logic [15:0] SEED = CRC_INIT
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // control and data
  input  wire logic        init_i,
  input  wire logic        shift_i,
  input  wire logic        bit_i,
  // result
  output logic             zero_o
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // seed wins over shift
  always_comb begin
    crc_nxt = crc_r;
    if (init_i) begin
      crc_nxt = SEED;
    end else if (shift_i) begin
      crc_nxt = {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ bit_i) ? POLY : 16'h0000);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_r <= 16'h0000;
    end else if (ce_i) begin
      crc_r <= crc_nxt;
    end
  end

  // whole message plus check word leaves no remainder
  assign zero_o = (crc_r == 16'h0000);

  a_crc_seed_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && init_i |=> !zero_o && crc_r == SEED)
    else $error("check engine not seeded");
endmodule : crc16_unit

// ---- verilog/two_entry_buffer.sv ----
// two-entry elastic buffer on the received-byte path
// assumes flush is a one-cycle pulse from the handler
module two_entry_buffer (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  input  wire logic   flush_i,
  // streams
  byte_stream_if.snk  in_s,
  byte_stream_if.src  out_s
);
  import rx_pkt_pkg::*;
  logic [7:0] mem_r [2];
  logic [7:0] mem_nxt [2];
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       push;
  logic       pop;

  // handshakes stall while the clock enable is low
  assign in_s.ready  = ce_i && (cnt_r != 2'd2);
  assign out_s.valid = ce_i && (cnt_r != 2'd0);
  assign out_s.data  = mem_r[0];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  // head always sits in entry 0
  always_comb begin
    mem_nxt = mem_r;
    cnt_nxt = cnt_r;
    if (pop) begin
      mem_nxt[0] = mem_r[1];
    end
    if (push) begin
      mem_nxt[(cnt_r == 2'd2 || (pop && cnt_r == 2'd1)) ? 0 : 32'(cnt_r) - (pop ? 1 : 0)]
        = in_s.data;
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    if (flush_i) begin
      cnt_nxt = 2'd0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      cnt_r    <= 2'd0;
    end else if (ce_i) begin
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_buf_no_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cnt_r == 2'd2 && !pop |-> !in_s.ready ##1 cnt_r != 2'd0 || $past(flush_i))
    else $error("buffer accepted a byte while full");
endmodule : two_entry_buffer

// ---- tb/rf_tx_model.sv ----
// far-end transmitter model: serialises frames onto the bit intake
// assumes inputs are sampled on the rising edge, drives on the falling edge
module rf_tx_model (
  // clock
  input  wire logic clk_i,
  // bit intake handshake
  input  wire logic ready_i,
  output logic      bit_o,
  output logic      valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // line idles low with no bit offered
  initial begin
    bit_o   = 1'b0;
    valid_o = 1'b0;
  end

  // hold the bit until the edge that takes it
  task automatic send_bit(input logic b);
    @(negedge clk_i);
    bit_o   = b;
    valid_o = 1'b1;
    do @(posedge clk_i); while (ready_i !== 1'b1);
  endtask : send_bit

  // msb first
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask : send_byte

  // preamble, pattern high byte then low byte, then the body
  task automatic send_frame(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d[$]);
    send_byte(8'h55);
    send_byte(hi);
    send_byte(lo);
    foreach (d[i]) send_byte(d[i]);
  endtask : send_frame

  // released line shows the inverse so stale data never looks valid
  task automatic release_line;
    @(negedge clk_i);
    valid_o = 1'b0;
    bit_o   = ~bit_o;
  endtask : release_line
endmodule : rf_tx_model

// ---- tb/test_rx_packet_handler.sv ----
// self-checking bench for the receive packet handler
// assumes the transmitter model and the design files are compiled first
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_rx_packet_handler;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_pkt_pkg::*;

  logic clk, rst, reg_wr, bit_s, bit_valid, bit_ready, fifo_valid, fifo_ready, flush, gout0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, fifo_data;
  logic [2:0]  gpins;
  logic [23:0] freq_word;
  logic [15:0] c;
  logic [7:0]  got[$];
  int          fail_count, n_tests, flushes, f0;
  logic [7:0]  ofs[8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
  logic [7:0]  rv[8]  = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h45, 8'h00, 8'h00, 8'h00};
  logic [7:0]  adr[3] = '{8'h00, 8'hff, 8'h33};

  rx_packet_handler dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rdata_o(reg_rdata), .bit_i(bit_s),
    .bit_valid_i(bit_valid), .bit_ready_o(bit_ready), .rssi_i(8'h3c), .fifo_data_o(fifo_data),
    .fifo_valid_o(fifo_valid), .fifo_ready_i(fifo_ready), .flush_o(flush),
    .general_output_zero_o(gout0), .general_output_pins_o(gpins),
    .base_freq_i(24'h100000), .spacing_i(16'h0200), .freq_word_o(freq_word));
  rf_tx_model tx (.clk_i(clk), .ready_i(bit_ready), .bit_o(bit_s), .valid_o(bit_valid));

  // 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // collect popped bytes and flush pulses
  always @(posedge clk) begin
    if (fifo_valid === 1'b1 && fifo_ready === 1'b1) got.push_back(fifo_data);
    if (flush === 1'b1) flushes++;
  end

  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // reads are combinational, so look once the address has settled
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    #1 `CHK(reg_rdata, e)
  endtask : rd_chk

  // bench-side check word over a queue, msb first
  function automatic logic [15:0] crc_of(input logic [7:0] d[$]);
    logic [15:0] r;
    r = 16'hffff;
    foreach (d[i]) for (int b = 7; b >= 0; b--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i][b]) ? 16'h8005 : 16'h0000);
    return r;
  endfunction : crc_of

  // adds the check word when add_crc is set and sends with the fixed c3 3c pattern
  task automatic send(input logic [7:0] d[$], input logic add_crc);
    c = crc_of(d);
    if (add_crc) begin d.push_back(c[15:8]); d.push_back(c[7:0]); end
    tx.send_frame(8'hc3, 8'h3c, d);
    tx.release_line();
  endtask : send

  // bounded wait for the handler to go back to hunting
  task automatic idle_wait;
    for (int k = 0; k < 300 && gpins[2] !== 1'b0; k++) @(negedge clk);
    repeat (6) @(negedge clk);
  endtask : idle_wait

  task automatic chk_q(input logic [7:0] e[$]);
    `CHK(got.size(), e.size())
    foreach (e[i]) if (i < got.size()) `CHK(got[i], e[i])
  endtask : chk_q

  // watchdog: all scenarios fit well inside this span
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; fifo_ready = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    foreach (ofs[i]) rd_chk(ofs[i], rv[i]);
    wr(OFS_SYNC_HI, 8'hc3); wr(OFS_SYNC_LO, 8'h3c); wr(OFS_ADDR, 8'h5a);
    wr(OFS_LIMIT, 8'h05);
    wr(OFS_CTRL_A, 8'h0d); wr(OFS_CTRL_B, 8'h05);
    rd_chk(OFS_SYNC_HI, 8'hc3);
    rd_chk(OFS_SYNC_LO, 8'h3c);
    // variable length, own address, receiver stalled so the buffer fills
    fifo_ready = 1'b0; got.delete();
    fork
      send('{8'h03, 8'h5a, 8'h11, 8'h22}, 1'b1);
      begin repeat (120) @(negedge clk); fifo_ready = 1'b1; end
    join
    idle_wait();
    chk_q('{8'h03, 8'h5a, 8'h11, 8'h22, 8'h3c, 8'h80});
    rd_chk(OFS_STATUS, 8'h80);
    // corrupted check word must flush
    f0 = flushes;
    send('{8'h03, 8'h5a, 8'h11, 8'h22, 8'h00, 8'h00}, 1'b0); idle_wait();
    `CHK(flushes - f0, 1)
    // length above the limit must be dropped
    f0 = flushes;
    send('{8'h06, 8'h5a, 8'h11, 8'h22}, 1'b1); idle_wait();
    `CHK(flushes - f0, 1)
    // every filter code against broadcast and foreign addresses
    for (int m = 0; m < 4; m++) foreach (adr[j]) begin
      wr(OFS_CTRL_A, 8'h0c | m[7:0]);
      f0 = flushes;
      send('{8'h02, adr[j], 8'h77}, 1'b1); idle_wait();
      `CHK(flushes - f0, (m == 0 || (m >= 2 && adr[j] == 8'h00) || (m == 3 && adr[j] == 8'hff)) ? 0 : 1)
    end
    // fixed length, with and without the check word
    wr(OFS_CTRL_A, 8'h0d); wr(OFS_LIMIT, 8'h03);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL_B, k ? 8'h00 : 8'h04);
      got.delete();
      send('{8'h5a, 8'h11, 8'h22}, k == 0); idle_wait();
      chk_q('{8'h5a, 8'h11, 8'h22, 8'h3c, 8'h80});
    end
    // channel word: base plus index times spacing
    wr(OFS_CHANNEL_INDEX, 8'h07);
    repeat (3) @(negedge clk);
    `CHK(freq_word, 24'h100e00)
    // synchronous serial: each taken bit shows on the data pin
    wr(OFS_CTRL_B, 8'h15);
    for (int i = 7; i >= 0; i--) begin
      tx.send_bit(c[i]);
      // look just after the taking edge; waiting a negedge would offer the bit twice
      #1 `CHK(gout0, c[i])
      `CHK(gpins[1:0], {1'b1, c[i]})
    end
    tx.release_line();
    // infinite length: bytes flow and the packet never closes by itself
    wr(OFS_CTRL_A, 8'h0c); wr(OFS_CTRL_B, 8'h02); got.delete();
    send('{8'h11, 8'h22, 8'h33}, 1'b0); repeat (6) @(negedge clk);
    chk_q('{8'h11, 8'h22, 8'h33});
    `CHK(gpins[2], 1'b1)
    // reset in mid-packet must bring back hunting and reset values
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_chk(OFS_CTRL_B, 8'h45);
    `CHK(gpins[2], 1'b0)
    `CHK(freq_word, 24'h100000)
    give_verdict();
  end
endmodule : test_rx_packet_handler
